// ### fmsq_defines.vh
// constants for the fft memory sequencer
// Summary of operation
// - after a load, stay idle; no transform begins until start arrives.
// - direction and scaling are captured on the clock edge where start is high in single- or two-bank layout.
// - single-bank results stay in the working bank, digit-reversed.
// - read addresses undo digit reversal so port b delivers natural order.
// - a load and an unload each last 1024 cycles, one sample per cycle.
// - single-bank output writes span cycles 3121 to 4144 after start.
// - two-bank last pass writes bank y while bank x takes new input.
// - host muxes port a input; core drives port_share_select to steer it.
// - output_frame_strobe frames each two-bank result burst exactly; bank y write enable.
// - results leave digit-permuted; reorder_address gives natural-order bank y addresses.
// - once started in two-bank layout, vectors run back to back.
// - port_share_select is high for exactly each input-load window of a two-bank run.
// - early_load_warning rises ahead of every input-load window of a two-bank run.
// - back to back, settings are captured only on settings_sample_strobe or on a restarting start.
// - two-bank: first done 4144 cycles after start, then every 5120.
// - reorder_address is a 10-bit radix-4 digit-reversed sequence.
`ifndef FMSQ_DEFINES_VH
`define FMSQ_DEFINES_VH

`define FMSQ_AW 10
`define FMSQ_CW 13
`define FMSQ_VEC_LAST 10'h3ff
`define FMSQ_SMS_OUT_FIRST 13'h0c31
`define FMSQ_SMS_OUT_LAST 13'h1030
`define FMSQ_SMS_DONE 13'h1031
`define FMSQ_DMS_OUT_FIRST 13'h0c30
`define FMSQ_DMS_OUT_LAST 13'h102f
`define FMSQ_DMS_DONE 13'h1030
`define FMSQ_DMS_PERIOD_LAST 13'h13ff
`define FMSQ_EARLY_LEAD 13'h0010
`define FMSQ_SET_STROBE_CNT 13'h0000

`define FMSQ_LAY_SINGLE 2'h2
`define FMSQ_LAY_THREE 2'h1
`define FMSQ_LAY_TWO 2'h3

`define FMSQ_OFF_CONFIG 4'h0
`define FMSQ_OFF_STATUS 4'h4
`define FMSQ_CFG_SEL0 0
`define FMSQ_CFG_SEL1 1
`define FMSQ_CFG_DIR 2
`define FMSQ_CFG_SCL_LO 3
`define FMSQ_CFG_SCL_HI 4
`define FMSQ_CFG_RESET 32'h0000_0002
`define FMSQ_RESP_OKAY 2'h0
`define FMSQ_RESP_SLVERR 2'h2

`endif

// ### fmsq_digit_rev.v
// radix-4 digit reversal of a 10-bit address
`timescale 1ns/1ps
`include "fmsq_defines.vh"

module fmsq_digit_rev (
  input wire [`FMSQ_AW-1:0] natural_addr, // natural-order index
  output wire [`FMSQ_AW-1:0] reversed_addr // base-4 digits in reverse order
);
  genvar d;
  generate
    for (d = 0; d < `FMSQ_AW / 2; d = d + 1) begin : g_digit
      assign reversed_addr[2*d+1:2*d] = natural_addr[`FMSQ_AW-1-2*d:`FMSQ_AW-2-2*d];
    end
  endgenerate
endmodule

// ### fmsq_sequencer.v
// fft memory sequencer: load, compute, unload and two-bank overlap control
`timescale 1ns/1ps
`include "fmsq_defines.vh"

module fmsq_sequencer (
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, active low
  input wire [3:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [3:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire start, // one-cycle transform start
  input wire load_request_pulse, // one-cycle load request
  input wire read_request_pulse, // one-cycle result read request
  output reg [`FMSQ_AW-1:0] work_addr_a, // working bank port a address
  output reg work_en_a, // working bank port a enable
  output reg work_we_a, // working bank port a write enable
  output reg [`FMSQ_AW-1:0] work_addr_b, // working bank port b address
  output reg work_en_b, // working bank port b enable
  output reg port_share_select, // port a mux: high selects input_sample_bus
  output reg early_load_warning, // load window is about to open
  output reg output_frame_strobe, // burst_output_bus valid, bank y write enable
  output reg [`FMSQ_AW-1:0] reorder_address, // bank y write address
  output reg settings_sample_strobe, // settings captured this cycle
  output reg transform_direction_q, // captured direction for the arithmetic
  output reg [1:0] scaling_select_q, // captured scaling for the arithmetic
  output reg done, // one-cycle transform complete
  output reg busy // sequencer not idle
);

  localparam ST_IDLE = 5'h01;
  localparam ST_LOAD = 5'h02;
  localparam ST_COMP = 5'h04;
  localparam ST_UNLD = 5'h08;
  localparam ST_RUN = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // register file
  reg [31:0] config_reg;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [`FMSQ_CW-1:0] cnt_reg;
  reg [`FMSQ_CW-1:0] cnt_next;
  reg [15:0] vector_count_reg;
  reg aw_taken_reg;
  reg w_taken_reg;
  reg [3:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire [1:0] layout = {config_reg[`FMSQ_CFG_SEL1], config_reg[`FMSQ_CFG_SEL0]};
  wire lay_single = (layout == `FMSQ_LAY_SINGLE);
  wire lay_two = (layout == `FMSQ_LAY_TWO);
  wire cfg_dir = config_reg[`FMSQ_CFG_DIR];
  wire [1:0] cfg_scl = config_reg[`FMSQ_CFG_SCL_HI:`FMSQ_CFG_SCL_LO];
  wire [31:0] status_word = {vector_count_reg, 6'h00, scaling_select_q, transform_direction_q,
                             lay_two, lay_single, state_reg};
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_taken_reg | aw_hs;
  wire w_have = w_taken_reg | w_hs;
  wire [3:0] wr_addr = aw_taken_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_taken_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_taken_reg ? w_strb_reg : s_axi_wstrb;
  wire wr_fire = aw_have & w_have;
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  integer b;

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      config_reg <= `FMSQ_CFG_RESET;
      aw_taken_reg <= 1'b0;
      w_taken_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FMSQ_RESP_OKAY;
    end else begin
      // one ready pulse per offered item, none while a response waits
      s_axi_awready <= ~aw_taken_reg & ~s_axi_awready & ~s_axi_bvalid & s_axi_awvalid;
      s_axi_wready <= ~w_taken_reg & ~s_axi_wready & ~s_axi_bvalid & s_axi_wvalid;
      if (aw_hs & ~wr_fire) begin
        aw_taken_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_hs & ~wr_fire) begin
        w_taken_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_taken_reg <= 1'b0;
        w_taken_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_addr == `FMSQ_OFF_CONFIG) begin
          s_axi_bresp <= `FMSQ_RESP_OKAY;
          for (b = 0; b < 4; b = b + 1) begin
            if (wr_strb[b]) begin
              config_reg[8*b +: 8] <= wr_data[8*b +: 8];
            end
          end
        end else if (wr_addr == `FMSQ_OFF_STATUS) begin
          s_axi_bresp <= `FMSQ_RESP_OKAY;
        end else begin
          s_axi_bresp <= `FMSQ_RESP_SLVERR;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `FMSQ_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        if (s_axi_araddr == `FMSQ_OFF_CONFIG) begin
          s_axi_rdata <= config_reg;
          s_axi_rresp <= `FMSQ_RESP_OKAY;
        end else if (s_axi_araddr == `FMSQ_OFF_STATUS) begin
          s_axi_rdata <= status_word;
          s_axi_rresp <= `FMSQ_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `FMSQ_RESP_SLVERR;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  wire start_ok = start & (lay_single | lay_two);
  wire cnt_last10 = (cnt_reg[`FMSQ_AW-1:0] == `FMSQ_VEC_LAST);

  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (start_ok & (lay_two | (state_reg == ST_IDLE))) begin
      // single bank only starts from idle; two bank restarts at any time
      state_next = lay_two ? ST_RUN : ST_COMP;
      cnt_next = {`FMSQ_CW{1'b0}};
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (load_request_pulse) begin
            state_next = ST_LOAD;
            cnt_next = {`FMSQ_CW{1'b0}};
          end else if (read_request_pulse & lay_single) begin
            state_next = ST_UNLD;
            cnt_next = {`FMSQ_CW{1'b0}};
          end
        end
        ST_LOAD, ST_UNLD: begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_last10) begin
            state_next = ST_IDLE;
          end
        end
        ST_COMP: begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == `FMSQ_SMS_DONE) begin
            state_next = ST_IDLE;
          end
        end
        ST_RUN: begin
          // free-running period, no further start needed
          if (cnt_reg == `FMSQ_DMS_PERIOD_LAST) begin
            cnt_next = {`FMSQ_CW{1'b0}};
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        default: begin
          state_next = ST_IDLE;
          cnt_next = {`FMSQ_CW{1'b0}};
        end
      endcase
    end
  end

  // output flags are derived from the next count so they align with it
  wire n_run = (state_next == ST_RUN);
  wire n_comp = (state_next == ST_COMP);
  wire n_sms_out = n_comp & (cnt_next >= `FMSQ_SMS_OUT_FIRST) & (cnt_next <= `FMSQ_SMS_OUT_LAST);
  wire n_dms_win = n_run & (cnt_next >= `FMSQ_DMS_OUT_FIRST) & (cnt_next <= `FMSQ_DMS_OUT_LAST);
  wire n_early = n_run & (cnt_next >= `FMSQ_DMS_OUT_FIRST - `FMSQ_EARLY_LEAD) &
                 (cnt_next < `FMSQ_DMS_OUT_FIRST);
  wire [`FMSQ_AW-1:0] n_idx = cnt_next[`FMSQ_AW-1:0];
  wire [`FMSQ_CW-1:0] n_ofs_sms = cnt_next - `FMSQ_SMS_OUT_FIRST;
  wire [`FMSQ_CW-1:0] n_ofs_dms = cnt_next - `FMSQ_DMS_OUT_FIRST;
  wire [`FMSQ_AW-1:0] n_idx_out = n_comp ? n_ofs_sms[`FMSQ_AW-1:0]
                                         : n_ofs_dms[`FMSQ_AW-1:0];
  wire n_done = (n_comp & (cnt_next == `FMSQ_SMS_DONE)) |
                (n_run & (cnt_next == `FMSQ_DMS_DONE));
  wire [`FMSQ_AW-1:0] n_idx_rev;
  wire [`FMSQ_AW-1:0] n_out_rev;
  // capture on the edge that closes the marked cycle
  wire settings_now = settings_sample_strobe & ~start_ok;

  fmsq_digit_rev u_rev_unload (
    .natural_addr(n_idx),
    .reversed_addr(n_idx_rev)
  );

  fmsq_digit_rev u_rev_out (
    .natural_addr(n_idx_out),
    .reversed_addr(n_out_rev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // phase state and transform bookkeeping
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= {`FMSQ_CW{1'b0}};
      vector_count_reg <= 16'h0000;
      done <= 1'b0;
      busy <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      busy <= (state_next != ST_IDLE);
      done <= n_done;
      if (start_ok) begin
        vector_count_reg <= 16'h0000;
      end else if (n_done) begin
        vector_count_reg <= vector_count_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settings capture: at start, then only on the marked cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      settings_sample_strobe <= 1'b0;
      transform_direction_q <= 1'b0;
      scaling_select_q <= 2'h0;
    end else begin
      if (start_ok | settings_now) begin
        transform_direction_q <= cfg_dir;
        scaling_select_q <= cfg_scl;
      end
      settings_sample_strobe <= n_run & (cnt_next == `FMSQ_SET_STROBE_CNT) & ~start_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory strobes and addresses
  always @(posedge aclk) begin
    if (!aresetn) begin
      work_addr_a <= {`FMSQ_AW{1'b0}};
      work_en_a <= 1'b0;
      work_we_a <= 1'b0;
      work_addr_b <= {`FMSQ_AW{1'b0}};
      work_en_b <= 1'b0;
      port_share_select <= 1'b0;
      early_load_warning <= 1'b0;
      output_frame_strobe <= 1'b0;
      reorder_address <= {`FMSQ_AW{1'b0}};
    end else begin
      // port a: host samples in load windows, in-place results otherwise
      work_en_a <= (state_next == ST_LOAD) | n_comp | n_run;
      work_we_a <= (state_next == ST_LOAD) | n_sms_out | n_dms_win;
      work_addr_a <= n_idx;
      port_share_select <= n_dms_win;
      early_load_warning <= n_early;
      output_frame_strobe <= n_dms_win;
      reorder_address <= n_dms_win ? n_out_rev : {`FMSQ_AW{1'b0}};
      // port b: compute operand reads, or unscrambled result reads
      work_en_b <= (state_next == ST_UNLD) | n_comp | n_run;
      work_addr_b <= (state_next == ST_UNLD) ? n_idx_rev : n_idx;
    end
  end

endmodule

// ### fmsq_sequencer_chk.sv
// assertions on the fft memory sequencer ports
`timescale 1ns/1ps
`include "fmsq_defines.vh"
module fmsq_sequencer_chk (
  input wire aclk, // clock
  input wire aresetn, // sync reset, active low
  input wire start, // transform start
  input wire load_request_pulse, // load request
  input wire read_request_pulse, // read request
  input wire busy, // not idle
  input wire work_we_a, // port a write enable
  input wire [`FMSQ_AW-1:0] work_addr_a, // port a address
  input wire port_share_select, // load window
  input wire early_load_warning, // early window flag
  input wire output_frame_strobe, // result frame
  input wire [`FMSQ_AW-1:0] reorder_address, // bank y address
  input wire settings_sample_strobe, // capture mark
  input wire transform_direction_q, // captured direction
  input wire [1:0] scaling_select_q, // captured scaling
  input wire done // transform complete
);
  ////////////////////////////////////////
  reg [10:0] run_reg;
  reg [9:0] ofs_reg;
  function automatic [9:0] rev4(input [9:0] a);
    rev4 = {a[1:0], a[3:2], a[5:4], a[7:6], a[9:8]};
  endfunction
  // length of the write run and index within the result frame
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_reg <= 11'h000;
      ofs_reg <= 10'h000;
    end else begin
      run_reg <= work_we_a ? run_reg + 11'h001 : 11'h000;
      ofs_reg <= output_frame_strobe ? ofs_reg + 10'h001 : 10'h000;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_warn_run;
    early_load_warning [*8] ##1 early_load_warning [*8];
  endsequence
  sequence s_window_opens;
    port_share_select && !early_load_warning;
  endsequence
  chk_load_first: assert property (load_request_pulse && !busy && !start && !read_request_pulse
    |=> work_we_a && work_addr_a == 10'h000) else $error("load did not begin at zero");
  chk_addr_step: assert property (work_we_a && $past(work_we_a) && !port_share_select
    && !$past(port_share_select) |-> work_addr_a == 10'($past(work_addr_a) + 10'h001))
    else $error("write address did not step");
  chk_we_len: assert property ($fell(work_we_a) |-> run_reg == 11'h400)
    else $error("write run not 1024 cycles");
  chk_frame_share: assert property (output_frame_strobe |-> port_share_select && work_we_a)
    else $error("result frame outside load window");
  chk_early_lead: assert property ($rose(early_load_warning) |-> s_warn_run ##1 s_window_opens)
    else $error("early warning lead wrong");
  chk_reorder_seq: assert property (reorder_address ==
    (output_frame_strobe ? rev4(ofs_reg) : 10'h000)) else $error("bad reorder address");
  chk_settings_cap: assert property ($changed(transform_direction_q) || $changed(scaling_select_q)
    |-> $past(start) || $past(settings_sample_strobe)) else $error("settings moved");
  chk_strobe_time: assert property (settings_sample_strobe |-> $past(done, 976))
    else $error("capture mark not 976 after done");
endmodule
bind fmsq_sequencer fmsq_sequencer_chk u_fmsq_sequencer_chk (.aclk, .aresetn, .start,
  .load_request_pulse, .read_request_pulse, .busy, .work_we_a, .work_addr_a, .port_share_select,
  .early_load_warning, .output_frame_strobe, .reorder_address, .settings_sample_strobe,
  .transform_direction_q, .scaling_select_q, .done);

// ### fmsq_host_model.sv
// host sample source and port a multiplexer beside the memory banks
`timescale 1ns/1ps
module fmsq_host_model (
  input wire aclk, // clock
  input wire port_share_select, // load window from the core
  input wire [15:0] result_bus, // in-place result data
  output reg [15:0] port_a_wdata, // port a write data
  output wire [15:0] port_b_wdata, // port b write data, unused
  output reg [10:0] window_len // samples sent in last window
);
  reg [15:0] sample_reg = 16'h0000;
  reg [10:0] cnt_reg = 11'h000;
  initial window_len = 11'h000;
  assign port_b_wdata = 16'h0000;
  always @* port_a_wdata = port_share_select ? sample_reg : result_bus;
  // samples only inside the window; outside it the bus toggles
  always @(posedge aclk) begin
    sample_reg <= port_share_select ? sample_reg + 16'h0001 : ~sample_reg;
    cnt_reg <= port_share_select ? cnt_reg + 11'h001 : 11'h000;
    if (!port_share_select && cnt_reg != 11'h000)
      window_len <= cnt_reg;
  end
endmodule

// ### fmsq_sequencer_bench.sv
// self-checking bench for the fft memory sequencer
`timescale 1ns/1ps
`include "fmsq_defines.vh"
module fmsq_sequencer_bench;
  reg aclk = 1'b0, aresetn = 1'b0, start = 1'b0, load_request_pulse = 1'b0;
  reg read_request_pulse = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  reg s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  reg [31:0] s_axi_wdata = 32'h0, rd;
  reg [15:0] result_bus = 16'h0;
  reg [2:0] r, r2;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, done, busy;
  wire work_en_a, work_we_a, work_en_b, port_share_select, early_load_warning;
  wire output_frame_strobe, settings_sample_strobe, transform_direction_q;
  wire [1:0] s_axi_bresp, s_axi_rresp, scaling_select_q;
  wire [31:0] s_axi_rdata;
  wire [9:0] work_addr_a, work_addr_b, reorder_address;
  wire [15:0] port_a_wdata, port_b_wdata;
  wire [10:0] window_len;
  integer seed = 32'h4937, err_count = 0, num_checks = 0, cyc = 0, t0 = 0;
  integer we0, we1, ps0, ew0, ss0, nd, n;
  integer dc [0:1];
  fmsq_sequencer u_fmsq_sequencer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .start(start),
    .load_request_pulse(load_request_pulse), .read_request_pulse(read_request_pulse),
    .work_addr_a(work_addr_a), .work_en_a(work_en_a), .work_we_a(work_we_a),
    .work_addr_b(work_addr_b), .work_en_b(work_en_b), .port_share_select(port_share_select),
    .early_load_warning(early_load_warning), .output_frame_strobe(output_frame_strobe),
    .reorder_address(reorder_address), .settings_sample_strobe(settings_sample_strobe),
    .transform_direction_q(transform_direction_q), .scaling_select_q(scaling_select_q),
    .done(done), .busy(busy));
  fmsq_host_model u_fmsq_host_model (.aclk(aclk), .port_share_select(port_share_select),
    .result_bus(result_bus), .port_a_wdata(port_a_wdata), .port_b_wdata(port_b_wdata),
    .window_len(window_len));
  initial forever #50 aclk = ~aclk;
  ////////////////////////////////////////
  function automatic [9:0] rev4(input [9:0] a);
    rev4 = {a[1:0], a[3:2], a[5:4], a[7:6], a[9:8]};
  endfunction
  task check(input string what, input [31:0] seen, input [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("Error %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task axi_wr(input [3:0] a, input [31:0] d);
    integer k;
    reg aw, w;
    aw = 1'b0;
    w = 1'b0;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      aw = aw | (s_axi_awready === 1'b1);
      w = w | (s_axi_wready === 1'b1);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!(aw && w));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
  endtask
  task axi_rd(input [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = {s_axi_rdata[29:0], s_axi_rresp};
  endtask
  // one load or one result read, checked address by address
  task scan(input integer rd_mode);
    integer k, j;
    k = 0;
    if (rd_mode) read_request_pulse <= 1'b1;
    else load_request_pulse <= 1'b1;
    @(posedge aclk);
    read_request_pulse <= 1'b0;
    load_request_pulse <= 1'b0;
    for (j = 0; j < 1024; j = j + 1) begin
      #1;
      if (rd_mode ? (work_en_b !== 1'b1 || work_addr_b !== rev4(j[9:0]))
          : (work_we_a !== 1'b1 || work_addr_a !== j[9:0])) k = k + 1;
      @(posedge aclk);
    end
    #1;
    check("scan errors", k, 0);
    check("idle after scan", {work_we_a, work_en_b, busy}, 0);
    @(posedge aclk);
  endtask
  task go(input [2:0] s, input [1:0] lay);
    axi_wr(`FMSQ_OFF_CONFIG, {27'h0, s, lay});
    check("write resp", s_axi_bresp, `FMSQ_RESP_OKAY);
    t0 = cyc + 2;
    {we0, we1, ps0, ew0, ss0, nd} = {-32'sd1, -32'sd1, -32'sd1, -32'sd1, -32'sd1, 32'sd0};
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
  endtask
  task upto(input integer c);
    while (cyc - t0 < c) @(posedge aclk);
  endtask
  ////////////////////////////////////////
  always @(posedge aclk) begin
    result_bus <= 16'($random(seed));
    #1;
    cyc = cyc + 1;
    n = cyc - t0;
    if (work_we_a === 1'b1 && we0 < 0) we0 = n;
    if (work_we_a === 1'b1) we1 = n;
    if (port_share_select === 1'b1 && ps0 < 0) ps0 = n;
    if (early_load_warning === 1'b1 && ew0 < 0) ew0 = n;
    if (settings_sample_strobe === 1'b1 && ss0 < 0) ss0 = n;
    if (done === 1'b1 && nd < 2) dc[nd] = n;
    if (done === 1'b1 && nd < 2) nd = nd + 1;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    err_count = err_count + 1;
    final_report;
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("busy at reset", busy, 0);
    axi_rd(`FMSQ_OFF_CONFIG);
    check("config reset", rd, {`FMSQ_CFG_RESET, `FMSQ_RESP_OKAY});
    axi_rd(4'h8);
    check("unmapped resp", rd[1:0], `FMSQ_RESP_SLVERR);
    $display("test reset finished");
    r = 3'($random(seed));
    scan(0);
    go(r, `FMSQ_LAY_SINGLE);
    upto(4200);
    check("first out write", we0, 3121);
    check("last out write", we1, 4144);
    check("single done", dc[0], 4145);
    check("single settings", {transform_direction_q, scaling_select_q}, {r[0], r[2:1]});
    scan(1);
    $display("test single bank finished");
    r = 3'($random(seed));
    r2 = ~r;
    scan(0);
    go(r, `FMSQ_LAY_TWO);
    upto(4500);
    check("first done", dc[0], 4144);
    check("window open", ps0, 3120);
    check("early warning", ew0, 3104);
    check("window samples", window_len, 1024);
    check("start settings", {transform_direction_q, scaling_select_q}, {r[0], r[2:1]});
    axi_wr(`FMSQ_OFF_CONFIG, {27'h0, r2, `FMSQ_LAY_TWO});
    upto(5130);
    check("capture mark", ss0, 5120);
    check("strobe settings", {transform_direction_q, scaling_select_q}, {r2[0], r2[2:1]});
    axi_wr(`FMSQ_OFF_CONFIG, {27'h0, r, `FMSQ_LAY_TWO});
    upto(9300);
    check("second done", dc[1], 9264);
    check("held settings", {transform_direction_q, scaling_select_q}, {r2[0], r2[2:1]});
    go(r, `FMSQ_LAY_TWO);
    upto(4150);
    check("restart done", dc[0], 4144);
    check("restart settings", {transform_direction_q, scaling_select_q}, {r[0], r[2:1]});
    $display("test two bank finished");
    final_report;
  end
endmodule
